// >>> design/mtif_pkg.sv
// Constants of the timer cluster and interrupt flag block.
// Assumes a single 125 MHz system clock that also serves as Fc.
// What this block does
// - Timer A flip-flop action on match: 00 clear, 01 toggle, 10 set.
// - Timer A run bit low stops timer A and clears its counter.
// - Timer A clock: Fc over 2^11,2^7,2^5,2^3,2^2,2^1, Fc, or pin.
// - Timer A mode: timer, reserved, divider output, PWM output.
// - Timer A has an 8-bit read/write compare buffer.
// - Ext line 3 keeps a falling-edge flag and a rising-edge flag.
// - Watchdog time-out flag latches until software clears it.
// - Ext 0 flag cleared by software and forced clear while disabled.
// - First status register holds seven software-cleared request flags.
// - Status flags read 1 as pending; CPU writes only clear them.
// - Reading the first and second status registers returns flags ANDed with their mask.
// - Second status holds UART, time base and ext 1 request flags.
// - Base counter overflow sets bit 0 until software clears it.
// - Writing 1 to timer B control bit 7 captures the count.
// - Timer B run bit low stops timer B and clears its counter.
// - Timer B clock: Fc over 2^12, 2^10, 2^7, or external pin.
// - Timer B mode bit: 0 plain timer, 1 capture mode.
// - Timer B has two 8-bit buffers that reset leaves unchanged.
// - Timer C mode bit: 0 plain timer, 1 window mode.
// - Timer C run bit low stops timer C and clears its counter.
// - Timer C clock: Fc over 2^23,2^13,2^8,2^3, Fc, or pin.
package mtif_pkg;
    // Register banks and offsets.
    localparam logic [1:0] BANK_TIMERS_A = 2'h0;
    localparam logic [1:0] BANK_TIMERS_B = 2'h1;
    localparam logic [3:0] OFF_TA_CTRL = 4'hB;
    localparam logic [3:0] OFF_TA_BUF = 4'hC;
    localparam logic [3:0] OFF_ST_EDGE = 4'hD;
    localparam logic [3:0] OFF_ST_FIRST = 4'hE;
    localparam logic [3:0] OFF_ST_SECOND = 4'hF;
    localparam logic [3:0] OFF_TB_CTRL = 4'h5;
    localparam logic [3:0] OFF_TB_BUF_A = 4'h6;
    localparam logic [3:0] OFF_TB_BUF_B = 4'h7;
    localparam logic [3:0] OFF_TC_CTRL = 4'h8;
    localparam logic [3:0] OFF_TC_BUF_HI = 4'h9;
    localparam logic [3:0] OFF_TC_BUF_LO = 4'hA;
    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] TA_BUF_RESET = 8'h00;
    localparam logic [15:0] TC_BUF_RESET = 16'h0000;
    // Implemented flag bits per status register.
    localparam logic [7:0] EDGE_IMPL = 8'h33;
    localparam logic [7:0] FIRST_IMPL = 8'hEF;
    localparam logic [7:0] SECOND_IMPL = 8'h7D;
    // Field positions.
    localparam int TA_FF_POS = 6;
    localparam int TA_RUN_POS = 5;
    localparam int TA_CLK_POS = 2;
    localparam int TB_CAP_POS = 7;
    localparam int TB_RUN_POS = 6;
    localparam int TB_CLK_POS = 4;
    localparam int TB_MODE_POS = 3;
    localparam int TC_MODE_POS = 4;
    localparam int TC_RUN_POS = 3;
    localparam int TC_CLK_POS = 0;
    localparam int FL_EXT3_FALL = 5;
    localparam int FL_EXT3_RISE = 4;
    localparam int FL_WDT = 1;
    localparam int FL_EXT0 = 0;
    localparam int FL_EXT5 = 7;
    localparam int FL_TC = 6;
    localparam int FL_CONV = 5;
    localparam int FL_EXT3 = 3;
    localparam int FL_TA = 2;
    localparam int FL_SPI = 1;
    localparam int FL_TB = 0;
    localparam int FL_UERR = 6;
    localparam int FL_RXF = 5;
    localparam int FL_TXE = 4;
    localparam int FL_TBASE = 3;
    localparam int FL_EXT1 = 2;
    localparam int FL_BASE = 0;
    localparam int PRESCALE_W = 23;
    // Prescaler exponents, one per prescaled clock select code.
    localparam int TA_DIV0 = 11;
    localparam int TA_DIV1 = 7;
    localparam int TA_DIV2 = 5;
    localparam int TA_DIV3 = 3;
    localparam int TA_DIV4 = 2;
    localparam int TA_DIV5 = 1;
    localparam int TB_DIV0 = 12;
    localparam int TB_DIV1 = 10;
    localparam int TB_DIV2 = 7;
    localparam int TC_DIV0 = 23;
    localparam int TC_DIV1 = 13;
    localparam int TC_DIV2 = 8;
    localparam int TC_DIV3 = 3;
    // Enumerations of modes and flip-flop actions.
    typedef enum logic [1:0] {
        MTIF_FF_CLEAR = 2'h0,
        MTIF_FF_TOGGLE = 2'h1,
        MTIF_FF_SET = 2'h2,
        MTIF_FF_RSVD = 2'h3
    } mtif_ff_t;
    typedef enum logic [1:0] {
        MTIF_TA_TIMER = 2'h0,
        MTIF_TA_RSVD = 2'h1,
        MTIF_TA_DIVIDER = 2'h2,
        MTIF_TA_PWM = 2'h3
    } mtif_ta_mode_t;
endpackage

// >>> design/mtif_timers.sv
// Timer A, B and C with their prescaler, and the three status flag registers.
// Assumes a CPU core on the same clock drives the banked register strobes,
// the masks and the event pulses; timer pins are asynchronous.
`timescale 1ns/100ps
module mtif_timers
    import mtif_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] reg_bank,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] irq_mask_first,
    input wire logic [7:0] irq_mask_second,
    input wire logic timer_a_pin,
    input wire logic timer_b_pin,
    input wire logic timer_c_pin,
    input wire logic ext3_pin,
    input wire logic ext0_event,
    input wire logic ext0_enable,
    input wire logic ext1_event,
    input wire logic ext5_event,
    input wire logic watchdog_timeout,
    input wire logic conversion_done,
    input wire logic serial_periph_event,
    input wire logic uart_rx_error,
    input wire logic uart_enable,
    input wire logic uart_rx_full,
    input wire logic uart_tx_empty,
    input wire logic time_base_tick,
    input wire logic base_counter_overflow,
    output logic timer_a_out
);

    // True when the low n bits of the prescaler are all ones.
    function automatic logic div_tick(input logic [PRESCALE_W-1:0] c,
                                      input int n);
        logic [PRESCALE_W-1:0] m;
        m = PRESCALE_W'((64'd1 << n) - 64'd1);
        return (c & m) == m;
    endfunction

    // Flag update: a CPU write clears zeros, a hardware set always wins.
    function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                             input logic wr,
                                             input logic [7:0] wd,
                                             input logic [7:0] set,
                                             input logic [7:0] impl);
        logic [7:0] kept;
        kept = wr ? (cur & wd) : cur;
        return (kept | set) & impl;
    endfunction

    logic [PRESCALE_W-1:0] prescale;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_prev;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic [7:0] ta_ctrl;
    logic [7:0] ta_buf;
    logic [7:0] ta_cnt;
    logic [7:0] tb_ctrl;
    logic [7:0] tb_buf_a;
    logic [7:0] tb_buf_b;
    logic [7:0] tb_cnt;
    logic [7:0] tc_ctrl;
    logic [15:0] tc_buf;
    logic [15:0] tc_cnt;
    logic [7:0] st_edge;
    logic [7:0] st_first;
    logic [7:0] st_second;
    logic ta_tick;
    logic tb_tick;
    logic tc_tick;
    logic ta_event;
    logic tb_event;
    logic tc_event;
    logic wr_ta_ctrl;
    logic wr_ta_buf;
    logic wr_edge;
    logic wr_first;
    logic wr_second;
    logic wr_tb_ctrl;
    logic wr_tb_a;
    logic wr_tb_b;
    logic wr_tc_ctrl;
    logic wr_tc_hi;
    logic wr_tc_lo;
    logic soft_capture;
    logic [7:0] set_edge;
    logic [7:0] set_first;
    logic [7:0] set_second;
    logic [7:0] next_rdata;
    mtif_ff_t ta_ff;
    mtif_ta_mode_t ta_mode;

    // Free-running prescaler shared by all three timers.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + PRESCALE_W'(1);
        end
    end

    // Two-stage synchronisers for the pins, then a third stage for edges.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            pin_prev <= 4'h0;
        end else begin
            pin_meta <= {ext3_pin, timer_c_pin, timer_b_pin, timer_a_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_rise = pin_sync & ~pin_prev;
    assign pin_fall = ~pin_sync & pin_prev;

    // Register write decode, bank by bank.
    assign wr_ta_ctrl = reg_wr && reg_bank == BANK_TIMERS_A &&
                        reg_addr == OFF_TA_CTRL;
    assign wr_ta_buf = reg_wr && reg_bank == BANK_TIMERS_A &&
                       reg_addr == OFF_TA_BUF;
    assign wr_edge = reg_wr && reg_bank == BANK_TIMERS_A &&
                     reg_addr == OFF_ST_EDGE;
    assign wr_first = reg_wr && reg_bank == BANK_TIMERS_A &&
                      reg_addr == OFF_ST_FIRST;
    assign wr_second = reg_wr && reg_bank == BANK_TIMERS_A &&
                       reg_addr == OFF_ST_SECOND;
    assign wr_tb_ctrl = reg_wr && reg_bank == BANK_TIMERS_B &&
                        reg_addr == OFF_TB_CTRL;
    assign wr_tb_a = reg_wr && reg_bank == BANK_TIMERS_B &&
                     reg_addr == OFF_TB_BUF_A;
    assign wr_tb_b = reg_wr && reg_bank == BANK_TIMERS_B &&
                     reg_addr == OFF_TB_BUF_B;
    assign wr_tc_ctrl = reg_wr && reg_bank == BANK_TIMERS_B &&
                        reg_addr == OFF_TC_CTRL;
    assign wr_tc_hi = reg_wr && reg_bank == BANK_TIMERS_B &&
                      reg_addr == OFF_TC_BUF_HI;
    assign wr_tc_lo = reg_wr && reg_bank == BANK_TIMERS_B &&
                      reg_addr == OFF_TC_BUF_LO;
    assign soft_capture = wr_tb_ctrl && reg_wdata[TB_CAP_POS];

    // Control registers; the capture bit is a strobe and is never stored.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ta_ctrl <= CTRL_RESET;
            tb_ctrl <= CTRL_RESET;
            tc_ctrl <= CTRL_RESET;
        end else begin
            if (wr_ta_ctrl) begin
                ta_ctrl <= reg_wdata;
            end
            if (wr_tb_ctrl) begin
                tb_ctrl <= {1'b0, reg_wdata[6:3], 3'h0};
            end
            if (wr_tc_ctrl) begin
                tc_ctrl <= {3'h0, reg_wdata[4:0]};
            end
        end
    end

    assign ta_ff = mtif_ff_t'(ta_ctrl[TA_FF_POS +: 2]);
    assign ta_mode = mtif_ta_mode_t'(ta_ctrl[1:0]);

    // Buffers for timers A and C, cleared by reset.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ta_buf <= TA_BUF_RESET;
            tc_buf <= TC_BUF_RESET;
        end else begin
            if (wr_ta_buf) begin
                ta_buf <= reg_wdata;
            end
            if (wr_tc_hi) begin
                tc_buf[15:8] <= reg_wdata;
            end
            if (wr_tc_lo) begin
                tc_buf[7:0] <= reg_wdata;
            end
        end
    end

    // Timer B buffers keep their contents across reset on purpose.
    always_ff @(posedge clock) begin
        if (wr_tb_a) begin
            tb_buf_a <= reg_wdata;
        end
        if (soft_capture) begin
            tb_buf_b <= tb_cnt;
        end else if (wr_tb_b) begin
            tb_buf_b <= reg_wdata;
        end
    end

    // Count clock selection for each timer.
    always_comb begin
        unique case (ta_ctrl[TA_CLK_POS +: 3])
            3'h0: ta_tick = div_tick(prescale, TA_DIV0);
            3'h1: ta_tick = div_tick(prescale, TA_DIV1);
            3'h2: ta_tick = div_tick(prescale, TA_DIV2);
            3'h3: ta_tick = div_tick(prescale, TA_DIV3);
            3'h4: ta_tick = div_tick(prescale, TA_DIV4);
            3'h5: ta_tick = div_tick(prescale, TA_DIV5);
            3'h6: ta_tick = 1'b1;
            3'h7: ta_tick = pin_rise[0];
        endcase
        unique case (tb_ctrl[TB_CLK_POS +: 2])
            2'h0: tb_tick = div_tick(prescale, TB_DIV0);
            2'h1: tb_tick = div_tick(prescale, TB_DIV1);
            2'h2: tb_tick = div_tick(prescale, TB_DIV2);
            2'h3: tb_tick = pin_rise[1];
        endcase
        unique case (tc_ctrl[TC_CLK_POS +: 3])
            3'h0: tc_tick = div_tick(prescale, TC_DIV0);
            3'h1: tc_tick = div_tick(prescale, TC_DIV1);
            3'h2: tc_tick = div_tick(prescale, TC_DIV2);
            3'h3: tc_tick = div_tick(prescale, TC_DIV3);
            3'h4: tc_tick = 1'b1;
            3'h7: tc_tick = pin_rise[2];
            default: tc_tick = 1'b0;
        endcase
    end

    // Match events; PWM and capture modes flag on wrap instead of match.
    assign ta_event = ta_ctrl[TA_RUN_POS] && ta_tick &&
                      ((ta_mode == MTIF_TA_PWM) ? (ta_cnt == 8'hFF) :
                       (ta_mode != MTIF_TA_RSVD && ta_cnt == ta_buf));
    assign tb_event = tb_ctrl[TB_RUN_POS] && tb_tick &&
                      (tb_ctrl[TB_MODE_POS] ? (tb_cnt == 8'hFF) :
                       (tb_cnt == tb_buf_a));
    assign tc_event = tc_ctrl[TC_RUN_POS] && tc_tick &&
                      (!tc_ctrl[TC_MODE_POS] || pin_sync[2]) &&
                      tc_cnt == tc_buf;

    // Timer A counter; a stopped timer is held at zero.
    always_ff @(posedge clock) begin
        if (!resetn || !ta_ctrl[TA_RUN_POS]) begin
            ta_cnt <= 8'h00;
        end else if (ta_tick && ta_mode != MTIF_TA_RSVD) begin
            if (ta_event) begin
                ta_cnt <= 8'h00;
            end else begin
                ta_cnt <= ta_cnt + 8'h01;
            end
        end
    end

    // Timer A output: flip-flop action on match, or PWM compare level.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            timer_a_out <= 1'b0;
        end else if (ta_mode == MTIF_TA_PWM) begin
            timer_a_out <= ta_ctrl[TA_RUN_POS] && (ta_cnt < ta_buf);
        end else if (ta_event) begin
            unique case (ta_ff)
                MTIF_FF_CLEAR: timer_a_out <= 1'b0;
                MTIF_FF_TOGGLE: timer_a_out <= ~timer_a_out;
                MTIF_FF_SET: timer_a_out <= 1'b1;
                MTIF_FF_RSVD: timer_a_out <= timer_a_out;
            endcase
        end
    end

    // Timer B counter; capture mode runs free and wraps.
    always_ff @(posedge clock) begin
        if (!resetn || !tb_ctrl[TB_RUN_POS]) begin
            tb_cnt <= 8'h00;
        end else if (tb_tick) begin
            if (tb_event) begin
                tb_cnt <= 8'h00;
            end else begin
                tb_cnt <= tb_cnt + 8'h01;
            end
        end
    end

    // Timer C counter; window mode counts only while its pin is high.
    always_ff @(posedge clock) begin
        if (!resetn || !tc_ctrl[TC_RUN_POS]) begin
            tc_cnt <= 16'h0000;
        end else if (tc_tick && (!tc_ctrl[TC_MODE_POS] || pin_sync[2])) begin
            if (tc_event) begin
                tc_cnt <= 16'h0000;
            end else begin
                tc_cnt <= tc_cnt + 16'h0001;
            end
        end
    end

    // Hardware set vectors for the three status registers.
    always_comb begin
        set_edge = 8'h00;
        set_edge[FL_EXT3_FALL] = pin_fall[3];
        set_edge[FL_EXT3_RISE] = pin_rise[3];
        set_edge[FL_WDT] = watchdog_timeout;
        set_edge[FL_EXT0] = ext0_event && ext0_enable;
        set_first = 8'h00;
        set_first[FL_EXT5] = ext5_event;
        set_first[FL_TC] = tc_event;
        set_first[FL_CONV] = conversion_done;
        set_first[FL_EXT3] = pin_rise[3] || pin_fall[3];
        set_first[FL_TA] = ta_event;
        set_first[FL_SPI] = serial_periph_event;
        set_first[FL_TB] = tb_event;
        set_second = 8'h00;
        set_second[FL_UERR] = uart_rx_error && uart_enable;
        set_second[FL_RXF] = uart_rx_full;
        set_second[FL_TXE] = uart_tx_empty;
        set_second[FL_TBASE] = time_base_tick;
        set_second[FL_EXT1] = ext1_event;
        set_second[FL_BASE] = base_counter_overflow;
    end

    // Flag storage; writes clear, events set, disables force clear.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_edge <= 8'h00;
            st_first <= 8'h00;
            st_second <= 8'h00;
        end else begin
            st_edge <= flag_next(st_edge, wr_edge, reg_wdata, set_edge,
                                 EDGE_IMPL & {7'h7F, ext0_enable});
            st_first <= flag_next(st_first, wr_first, reg_wdata, set_first,
                                  FIRST_IMPL);
            st_second <= flag_next(st_second, wr_second, reg_wdata,
                                   set_second, SECOND_IMPL &
                                   {1'b0, uart_enable, 6'h3F});
        end
    end

    // Read multiplexer; first and second status reads are masked, unmapped reads are zero.
    always_comb begin
        next_rdata = 8'h00;
        if (reg_bank == BANK_TIMERS_A) begin
            unique case (reg_addr)
                OFF_TA_CTRL: next_rdata = ta_ctrl;
                OFF_TA_BUF: next_rdata = ta_buf;
                OFF_ST_EDGE: next_rdata = st_edge;
                OFF_ST_FIRST: next_rdata = st_first & irq_mask_first;
                OFF_ST_SECOND: next_rdata = st_second & irq_mask_second;
                default: next_rdata = 8'h00;
            endcase
        end else if (reg_bank == BANK_TIMERS_B) begin
            unique case (reg_addr)
                OFF_TB_CTRL: next_rdata = tb_ctrl;
                OFF_TB_BUF_A: next_rdata = tb_buf_a;
                OFF_TB_BUF_B: next_rdata = tb_buf_b;
                OFF_TC_CTRL: next_rdata = tc_ctrl;
                OFF_TC_BUF_HI: next_rdata = tc_buf[15:8];
                OFF_TC_BUF_LO: next_rdata = tc_buf[7:0];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Read data is registered, so it lands one cycle after the strobe.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking mtif_cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_ta_stop_clear: assert property (
        !ta_ctrl[TA_RUN_POS] |=> ta_cnt == 8'h00)
        else $error("timer A not cleared while stopped");

    a_tb_stop_clear: assert property (
        !tb_ctrl[TB_RUN_POS] |=> tb_cnt == 8'h00)
        else $error("timer B not cleared while stopped");

    a_tc_stop_clear: assert property (
        !tc_ctrl[TC_RUN_POS] |=> tc_cnt == 16'h0000)
        else $error("timer C not cleared while stopped");

    a_ta_fc_count: assert property (
        ta_ctrl[TA_RUN_POS] && ta_ctrl[TA_CLK_POS +: 3] == 3'h6 &&
        ta_mode == MTIF_TA_TIMER && ta_cnt != ta_buf && !wr_ta_ctrl
        |=> ta_cnt == $past(ta_cnt) + 8'h01)
        else $error("timer A missed an Fc tick");

    a_ta_match_restart: assert property (
        ta_event && ta_mode != MTIF_TA_PWM && !wr_ta_ctrl
        |=> ta_cnt == 8'h00 && st_first[FL_TA])
        else $error("timer A match did not restart and flag");

    a_ff_set_match: assert property (
        ta_event && ta_mode == MTIF_TA_DIVIDER && ta_ff == MTIF_FF_SET
        |=> timer_a_out)
        else $error("timer A flip-flop not set on match");

    a_ext0_forced: assert property (
        !ext0_enable |=> !st_edge[FL_EXT0])
        else $error("ext 0 flag kept while disabled");

    a_wdt_sticky: assert property (
        st_edge[FL_WDT] && !wr_edge |=> st_edge[FL_WDT])
        else $error("watchdog flag dropped without a write");

    a_no_soft_set: assert property (
        wr_first && !st_first[FL_EXT5] && !ext5_event
        |=> !st_first[FL_EXT5])
        else $error("CPU write set a request flag");

    a_read_masked: assert property (
        reg_rd && reg_bank == BANK_TIMERS_A && reg_addr == OFF_ST_SECOND
        |=> reg_rdata == ($past(st_second) & $past(irq_mask_second)))
        else $error("status read not masked");

    a_soft_capture: assert property (
        soft_capture |=> tb_buf_b == $past(tb_cnt))
        else $error("software capture lost the count");

    a_base_overflow: assert property (
        base_counter_overflow |=> st_second[FL_BASE][*2] or
        (st_second[FL_BASE] ##1 $past(wr_second)))
        else $error("base overflow flag not held");

endmodule // mtif_timers

// >>> verif/mtif_cpu_model.sv
// CPU core model: banked register reads and writes.
// Assumes the block takes strobes on the rising clock edge.
`timescale 1ns/100ps
module mtif_cpu_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic [1:0] reg_bank,
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    // The bus idles with no strobe raised.
    initial begin
        {reg_bank, reg_addr} = 6'h00;
        {reg_wr, reg_rd} = 2'h0;
        reg_wdata = 8'h00;
    end

    // One access spans one rising edge. Data is inverted on release so a
    // stale value is never mistaken for a fresh one.
    task automatic access(input logic w, input logic [5:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge clock);
        {reg_bank, reg_addr} = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge clock);
        q = reg_rdata;
        {reg_wr, reg_rd} = 2'h0;
        reg_wdata = ~d;
    endtask
endmodule // mtif_cpu_model

// >>> verif/tb.sv
// Self-checking bench for the timer cluster and its status flags.
// Assumes the CPU model is the only register bus master.
`timescale 1ns/100ps
module tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] mask1 = 8'hFF;
    logic [7:0] mask2 = 8'hFF;
    logic [2:0] pin = 3'h0;
    logic ext3 = 1'b0;
    logic [10:0] ev = 11'h000;
    logic ext0_en = 1'b1;
    logic uart_en = 1'b1;
    logic [1:0] bank;
    logic [3:0] addr;
    logic wr_s;
    logic rd_s;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] q;
    logic ta_out;
    int failures = 0;
    int comparisons = 0;
    int nh;
    int nt;

    initial forever #4 clock = ~clock;

    mtif_cpu_model u_cpu (.clock(clock), .reg_rdata(rdata),
        .reg_bank(bank), .reg_addr(addr), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_wdata(wdata));

    mtif_timers u_mtif_timers (.clock(clock), .resetn(resetn),
        .reg_bank(bank), .reg_addr(addr), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_wdata(wdata), .reg_rdata(rdata), .irq_mask_first(mask1),
        .irq_mask_second(mask2), .timer_a_pin(pin[0]),
        .timer_b_pin(pin[1]), .timer_c_pin(pin[2]), .ext3_pin(ext3),
        .ext0_event(ev[0]), .ext0_enable(ext0_en), .ext1_event(ev[1]),
        .ext5_event(ev[2]), .watchdog_timeout(ev[3]),
        .conversion_done(ev[4]), .serial_periph_event(ev[5]),
        .uart_rx_error(ev[6]), .uart_enable(uart_en),
        .uart_rx_full(ev[7]), .uart_tx_empty(ev[8]),
        .time_base_tick(ev[9]), .base_counter_overflow(ev[10]),
        .timer_a_out(ta_out));

    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_cpu.access(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string s, input logic [5:0] a,
                         input logic [7:0] e);
        u_cpu.access(1'b0, a, 8'h00, q);
        chk(s, e, q);
    endtask

    // Polls a status register; a bounded poll keeps a dead timer from
    // hanging the run.
    task automatic waitf(input logic [5:0] a, input logic [7:0] m,
                         input int lim);
        for (int i = 0; i < lim; i++) begin
            u_cpu.access(1'b0, a, 8'h00, q);
            if ((q & m) === m) return;
        end
        chk("flag wait", m, q & m);
        conclude();
    endtask

    // Counts high cycles and toggles of the timer A output.
    task automatic watch(input int w);
        logic p;
        p = ta_out;
        nh = 0;
        nt = 0;
        repeat (w) begin
            @(negedge clock);
            nh += (ta_out === 1'b1);
            nt += (ta_out !== p);
            p = ta_out;
        end
    endtask

    // Pulses a timer pin slowly enough to survive the synchroniser.
    task automatic tick(input int i, input int k);
        repeat (k) begin
            pin[i] = 1'b1;
            repeat (3) @(negedge clock);
            pin[i] = 1'b0;
            repeat (3) @(negedge clock);
        end
    endtask

    // Main sequence; inputs change only at falling edges.
    initial begin
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        rdchk("ta_ctrl", 6'h0B, 8'h00);
        wr(6'h0C, 8'hA5);
        rdchk("ta_buf", 6'h0C, 8'hA5);
        wr(6'h16, 8'h5A);
        wr(6'h18, 8'hFF);
        rdchk("tc_ctrl", 6'h18, 8'h1F);
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        rdchk("tb_buf_a", 6'h16, 8'h5A);
        $display("test registers done");
        ev = 11'h7FF;
        @(negedge clock);
        ev = 11'h000;
        rdchk("st_edge", 6'h0D, 8'h03);
        rdchk("st_first", 6'h0E, 8'hA2);
        rdchk("st_second", 6'h0F, 8'h7D);
        mask1 = 8'h80;
        rdchk("st_first", 6'h0E, 8'h80);
        mask1 = 8'hFF;
        wr(6'h0E, 8'h7F);
        wr(6'h0F, 8'hFE);
        rdchk("st_first", 6'h0E, 8'h22);
        rdchk("st_second", 6'h0F, 8'h7C);
        mask2 = 8'h41;
        rdchk("st_second", 6'h0F, 8'h40);
        mask2 = 8'hFF;
        {uart_en, ext0_en} = 2'h0;
        rdchk("st_second", 6'h0F, 8'h3C);
        rdchk("st_edge", 6'h0D, 8'h02);
        wr(6'h0D, 8'h00);
        ext3 = 1'b1;
        repeat (6) @(negedge clock);
        ext3 = 1'b0;
        repeat (6) @(negedge clock);
        rdchk("st_edge", 6'h0D, 8'h30);
        {uart_en, ext0_en} = 2'h3;
        $display("test flags done");
        // Buffer 0 makes every tick a match, so toggles count ticks.
        wr(6'h0C, 8'h00);
        for (int c = 3; c < 7; c++) begin
            wr(6'h0B, {2'h1, 1'b1, 3'(c), 2'h0});
            watch(256);
            nh = (nt >= (256 >> (6 - c)) - 1 && nt <= (256 >> (6 - c)) + 1);
            chk("ta_ticks", 8'h01, 8'(nh));
        end
        wr(6'h0B, 8'h7C);
        nh = ta_out;
        tick(0, 5);
        repeat (5) @(negedge clock);
        chk("ta_ext", 8'(!nh), 8'(ta_out));
        // Clear first, so that the set action must raise a low output.
        wr(6'h0B, 8'h38);
        wr(6'h0B, 8'hBA);
        watch(8);
        watch(16);
        chk("ta_set", 8'h10, 8'(nh));
        wr(6'h0B, 8'h38);
        watch(8);
        watch(16);
        chk("ta_clear", 8'h00, 8'(nh));
        wr(6'h0C, 8'h80);
        wr(6'h0B, 8'h3B);
        watch(16);
        watch(256);
        chk("ta_pwm", 8'h80, 8'(nh));
        wr(6'h0B, 8'h18);
        wr(6'h0E, 8'h00);
        repeat (20) @(negedge clock);
        rdchk("ta_stop", 6'h0E, 8'h00);
        $display("test timer a done");
        wr(6'h16, 8'h02);
        wr(6'h15, 8'h60);
        waitf(6'h0E, 8'h01, 400);
        wr(6'h15, 8'h38);
        wr(6'h15, 8'h78);
        tick(1, 5);
        repeat (5) @(negedge clock);
        wr(6'h15, 8'hF8);
        rdchk("tb_capture", 6'h17, 8'h05);
        wr(6'h15, 8'h38);
        wr(6'h15, 8'hB8);
        rdchk("tb_cleared", 6'h17, 8'h00);
        $display("test timer b done");
        wr(6'h19, 8'h00);
        wr(6'h1A, 8'h02);
        wr(6'h18, 8'h1C);
        wr(6'h0E, 8'h00);
        mask1 = 8'h40;
        repeat (40) @(negedge clock);
        rdchk("tc_window", 6'h0E, 8'h00);
        pin[2] = 1'b1;
        waitf(6'h0E, 8'h40, 20);
        $display("test timer c done");
        conclude();
    end
endmodule // tb
